/* File: adc_conversion_control.sv */
// conversion control: registers, sequencer, result formatting
// assumes comparator output from the analog core is asynchronous
//
// The address-and-strobe port was decided locally.
`timescale 1ns/1ns
`default_nettype none
module adc_conversion_control
  import adc_ctrl_pkg::*;
(
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       srst,
  // register port
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic [7:0]      reg_rdata,
  // interrupt request
  output logic            conv_irq,
  // analog core
  input  wire logic       comp_high,
  output logic [9:0]      dac_code,
  output logic            converter_on,
  output logic            reference_select,
  output logic [1:0]      channel_select,
  output logic            sample_hold,
  output logic            hold_discharge,
  // pins
  output logic [3:0]      pin_analog_select
);
  logic [7:0]  ctrl_q, ctrl_d, pin_q, pin_d;
  logic [9:0]  res_q, res_d;
  logic        done_q, done_d, ie_q, ie_d;
  logic [7:0]  rdata_q, rdata_d;
  logic        irq_q, irq_d, samp_q, samp_d;
  conv_state_t st_q, st_d;
  logic [3:0]  per_q, per_d;
  logic [1:0]  dly_q, dly_d;
  logic        comp_s1_q, comp_s2_q;
  logic        tick, run, sar_load, sar_step;
  logic [9:0]  trial;
  logic        wr_ctrl, go_set, go_clr, finish;

  adc_bit_clock u_clk (
    .ref_clk    (ref_clk),
    .srst       (srst),
    .run        (run),
    .clk_select (pin_q[CLKSEL_LSB +: 3]),
    .tick       (tick)
  );

  adc_sar #(.WIDTH(10)) u_sar (
    .ref_clk   (ref_clk),
    .srst      (srst),
    .load      (sar_load),
    .step      (sar_step),
    .comp_high (comp_s2_q),
    .trial     (trial)
  );

  function automatic logic [7:0] res_byte(input logic [9:0] r, input logic right,
                                          input logic high);
    if (right) begin
      res_byte = high ? {6'h00, r[9:8]} : r[7:0];
    end else begin
      res_byte = high ? r[9:2] : {r[1:0], 6'h00};
    end
  endfunction : res_byte

  always_ff @(posedge ref_clk) begin
    comp_s1_q <= comp_high;
    comp_s2_q <= comp_s1_q;
  end

  assign wr_ctrl  = reg_wr && reg_addr == CONTROL_ADDR;
  assign go_set   = wr_ctrl && reg_wdata[GO_BIT] && ctrl_q[ON_BIT];
  assign go_clr   = wr_ctrl && !reg_wdata[GO_BIT];
  // bit clock idles in the start delay and restarts on abort entry
  assign run      = (st_q == ST_CONV && !(go_clr || !ctrl_q[ON_BIT])) ||
                    st_q == ST_ABORT;
  assign sar_load = st_q == ST_DELAY && st_d == ST_CONV;
  // first period samples, ten periods resolve bits
  assign sar_step = st_q == ST_CONV && tick && per_q != 4'd0;
  assign finish   = st_q == ST_CONV && tick && per_q == 4'(CONV_PERIODS - 1);

  // sequencer
  always_comb begin
    st_d  = st_q;
    per_d = per_q;
    dly_d = dly_q;
    unique case (st_q)
      ST_IDLE: begin
        if (go_set) begin
          st_d  = ST_DELAY;
          dly_d = '0;
        end
      end
      ST_DELAY: begin
        // rc clock waits one instruction so the core runs quiet
        if (pin_q[CLKSEL_LSB +: 2] != 2'b11 || dly_q == 2'(INSTR_CYCLES - 1)) begin
          st_d  = ST_CONV;
          per_d = '0;
        end else begin
          dly_d = dly_q + 1'b1;
        end
        if (go_clr || !ctrl_q[ON_BIT]) begin
          st_d = ST_IDLE;
        end
      end
      ST_CONV: begin
        if (go_clr || !ctrl_q[ON_BIT]) begin
          st_d  = ST_ABORT;
          dly_d = '0;
        end else if (finish) begin
          st_d = ST_IDLE;
        end else if (tick) begin
          per_d = per_q + 1'b1;
        end
      end
      ST_ABORT: begin
        if (tick) begin
          dly_d = dly_q + 1'b1;
          if (dly_q == 2'(ABORT_PERIODS - 1)) begin
            st_d = ST_IDLE;
          end
        end
      end
    endcase
  end

  // registers
  always_comb begin
    ctrl_d = ctrl_q;
    pin_d  = pin_q;
    ie_d   = ie_q;
    done_d = done_q;
    res_d  = res_q;
    if (wr_ctrl) begin
      ctrl_d = reg_wdata & CONTROL_MASK;
      ctrl_d[GO_BIT] = (reg_wdata[GO_BIT] && ctrl_q[ON_BIT]) ||
                       (ctrl_q[GO_BIT] && reg_wdata[GO_BIT]);
    end
    if (reg_wr && reg_addr == PIN_CLK_ADDR) begin
      pin_d = reg_wdata & PIN_CLK_MASK;
    end
    if (reg_wr && reg_addr == ENABLE_ADDR) begin
      ie_d = reg_wdata[DONE_BIT];
    end
    if (reg_wr && reg_addr == FLAG_ADDR) begin
      done_d = reg_wdata[DONE_BIT];
    end
    if (finish && st_d == ST_IDLE) begin
      ctrl_d[GO_BIT] = 1'b0;
      done_d         = 1'b1;
      // last tick decides bit 0 alongside the sar
      res_d          = {trial[9:1], comp_s2_q};
    end
    if (st_q == ST_ABORT || (st_q == ST_DELAY && st_d == ST_IDLE)) begin
      ctrl_d[GO_BIT] = 1'b0;
    end
  end

  // outputs and read data
  always_comb begin
    rdata_d = 8'h00;
    if (reg_rd) begin
      unique case (reg_addr)
        CONTROL_ADDR:   rdata_d = ctrl_q;
        PIN_CLK_ADDR:   rdata_d = pin_q;
        RESULT_HI_ADDR: rdata_d = res_byte(res_q, ctrl_q[JUSTIFY_BIT], 1'b1);
        RESULT_LO_ADDR: rdata_d = res_byte(res_q, ctrl_q[JUSTIFY_BIT], 1'b0);
        FLAG_ADDR:      rdata_d = 8'(done_q) << DONE_BIT;
        ENABLE_ADDR:    rdata_d = 8'(ie_q) << DONE_BIT;
        default:        rdata_d = 8'h00;
      endcase
    end
    irq_d  = done_d && ie_d;
    samp_d = ctrl_d[ON_BIT] &&
             (st_d == ST_IDLE || st_d == ST_DELAY || (st_d == ST_CONV && per_d == 4'd0));
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ctrl_q  <= CONTROL_RESET;
      pin_q   <= PIN_CLK_RESET;
      ie_q    <= 1'b0;
      done_q  <= 1'b0;
      rdata_q <= 8'h00;
      irq_q   <= 1'b0;
      samp_q  <= 1'b0;
      st_q    <= ST_IDLE;
      per_q   <= '0;
      dly_q   <= '0;
    end else begin
      ctrl_q  <= ctrl_d;
      pin_q   <= pin_d;
      ie_q    <= ie_d;
      done_q  <= done_d;
      rdata_q <= rdata_d;
      irq_q   <= irq_d;
      samp_q  <= samp_d;
      st_q    <= st_d;
      per_q   <= per_d;
      dly_q   <= dly_d;
    end
  end

  // result survives reset
  always_ff @(posedge ref_clk) begin
    res_q <= res_d;
  end

  logic [9:0] dac_q;
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      dac_q <= '0;
    end else begin
      dac_q <= trial;
    end
  end

  assign reg_rdata         = rdata_q;
  assign conv_irq          = irq_q;
  assign dac_code          = dac_q;
  assign converter_on      = ctrl_q[ON_BIT];
  assign reference_select  = ctrl_q[REF_BIT];
  assign channel_select    = ctrl_q[CHAN_LSB +: 2];
  assign sample_hold       = samp_q;
  assign hold_discharge    = 1'b0;
  assign pin_analog_select = pin_q[3:0];
endmodule : adc_conversion_control
`default_nettype wire

/* File: adc_ctrl_pkg.sv */
// constants shared by the conversion control block
// assumes a single 25 MHz system clock and a plain register port
// How it works
// - each result is a 10-bit successive approximation value held for software.
// - channel select 00..11 routes input 0..3 to the sample-and-hold.
// - reference select bit 6 picks external reference pin, else supply.
// - a conversion lasts exactly eleven conversion bit periods.
// - clock select picks divide 2,4,8,16,32,64 or internal RC for x11.
// - internal RC conversion clock runs at 500 kHz or less.
// - writing go bit 1 while converter-on is already set starts conversion; reads one while busy.
// - at completion go clears, done flag bit 6 sets, request raised if enabled.
// - clearing go mid-conversion aborts and keeps the previous result.
// - after abort wait two bit periods, then acquire selected channel.
// - justify bit 7 one gives right-justified, zero left-justified result.
// - converter-on bit 0 powers converter; zero shuts it off.
// - analog select bit makes pin analog and disables its digital functions.
// - analog select bits reset to one, all other control bits to zero.
// - control bits 5 and 4 and analog select bit 7 read as zero.
// - hold capacitor is never discharged between conversions.
// - with internal RC clock, start is delayed one instruction cycle.
// - reset turns converter off, aborts conversion, keeps result registers.
package adc_ctrl_pkg;
  localparam logic [7:0] CONTROL_ADDR     = 8'h1F;
  localparam logic [7:0] PIN_CLK_ADDR     = 8'h9F;
  localparam logic [7:0] RESULT_HI_ADDR   = 8'h1E;
  localparam logic [7:0] RESULT_LO_ADDR   = 8'h9E;
  localparam logic [7:0] FLAG_ADDR        = 8'h0C;
  localparam logic [7:0] ENABLE_ADDR      = 8'h8C;
  localparam int         JUSTIFY_BIT      = 7;
  localparam int         REF_BIT          = 6;
  localparam int         CHAN_LSB         = 2;
  localparam int         GO_BIT           = 1;
  localparam int         ON_BIT           = 0;
  localparam int         CLKSEL_LSB       = 4;
  localparam int         DONE_BIT         = 6;
  localparam logic [7:0] CONTROL_MASK     = 8'hCF;
  localparam logic [7:0] PIN_CLK_MASK     = 8'h7F;
  localparam logic [7:0] CONTROL_RESET    = 8'h00;
  localparam logic [7:0] PIN_CLK_RESET    = 8'h0F;
  localparam int         CONV_PERIODS     = 11;
  localparam int         ABORT_PERIODS    = 2;
  localparam int         CLK_HZ           = 25000000;
  localparam int         RC_MAX_HZ        = 500000;
  localparam int         INSTR_CYCLES     = 4;
  // internal rc bit period in system clocks, shortest period rounded up
  localparam int         RC_DIV           = (CLK_HZ + RC_MAX_HZ - 1) / RC_MAX_HZ;
  localparam int         DIV_W            = 7;
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_DELAY = 2'b01,
    ST_CONV  = 2'b10,
    ST_ABORT = 2'b11
  } conv_state_t;
endpackage : adc_ctrl_pkg

/* File: adc_bit_clock.sv */
// conversion bit period tick generator
// assumes run is held high for as long as ticks are wanted
`timescale 1ns/1ns
`default_nettype none
module adc_bit_clock
  import adc_ctrl_pkg::*;
(
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       srst,
  // control
  input  wire logic       run,
  input  wire logic [2:0] clk_select,
  // tick out
  output logic            tick
);
  logic [DIV_W-1:0] cnt_q, cnt_d, lim;

  function automatic logic [DIV_W-1:0] div_limit(input logic [2:0] sel);
    if (sel[1:0] == 2'b11) begin
      div_limit = DIV_W'(RC_DIV - 1);
    end else begin
      // low bits pick 2/8/32, top bit doubles
      div_limit = DIV_W'((2 << (2 * sel[1:0] + {1'b0, sel[2]})) - 1);
    end
  endfunction : div_limit

  always_comb begin
    lim   = div_limit(clk_select);
    cnt_d = cnt_q;
    if (!run || cnt_q >= lim) begin
      cnt_d = '0;
    end else begin
      cnt_d = cnt_q + 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign tick = run && (cnt_q >= lim);
endmodule : adc_bit_clock
`default_nettype wire

/* File: adc_sar.sv */
// successive approximation register, one decision per bit period
// assumes comparator input settles within one bit period
`timescale 1ns/1ns
`default_nettype none
module adc_sar
  import adc_ctrl_pkg::*;
#(
  parameter int WIDTH = 10
) (
  // clock and reset
  input  wire logic             ref_clk,
  input  wire logic             srst,
  // sequencing
  input  wire logic             load,
  input  wire logic             step,
  input  wire logic             comp_high,
  // trial code to the core and final code
  output logic [WIDTH-1:0]      trial
);
  logic [WIDTH-1:0] code_q, code_d, mask_q, mask_d;

  always_comb begin
    code_d = code_q;
    mask_d = mask_q;
    if (load) begin
      mask_d = {1'b1, {(WIDTH-1){1'b0}}};
      code_d = mask_d;
    end else if (step && mask_q != '0) begin
      // keep or drop the trial bit, then try the next lower one
      code_d = (comp_high ? code_q : (code_q & ~mask_q)) | (mask_q >> 1);
      mask_d = mask_q >> 1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      code_q <= '0;
      mask_q <= '0;
    end else begin
      code_q <= code_d;
      mask_q <= mask_d;
    end
  end

  assign trial = code_q;
endmodule : adc_sar
`default_nettype wire

/* File: adc_core_model.sv */
// behavioural analog core: channel mux, hold capacitor, comparator
// assumes trial codes and sample strobe from the conversion control block
`timescale 1ns/1ns
`default_nettype none
module adc_core_model #(
  parameter logic [39:0] VIN = 40'h0
) (
  // clock
  input  wire logic       ref_clk,
  // from control block
  input  wire logic [9:0] dac_code,
  input  wire logic       converter_on,
  input  wire logic       reference_select,
  input  wire logic [1:0] channel_select,
  input  wire logic       sample_hold,
  // to control block
  output logic            comp_high
);
  logic [10:0] held_q = 11'h000;
  logic        wander_q = 1'b0;
  logic [9:0]  vin;
  // pins are inputs only: the model alone sets their levels
  assign vin = VIN[channel_select * 10 +: 10];
  always_ff @(posedge ref_clk) begin
    wander_q <= ~wander_q;
    // held level kept between conversions, never cleared
    if (converter_on && sample_hold) begin
      held_q <= reference_select ? {1'b0, vin[9:1], 1'b1} : {vin, 1'b1};
    end
  end
  // half-step offset makes the final code equal the input level
  assign comp_high = converter_on ? (held_q > {dac_code, 1'b0}) : wander_q;
endmodule : adc_core_model
`default_nettype wire

/* File: adc_ctrl_chk.sv */
// port-level checks of the conversion control block
// assumes one clock domain and the register map of the package
`timescale 1ns/1ns
`default_nettype none
module adc_ctrl_chk
  import adc_ctrl_pkg::*;
(
  // clock and reset
  input wire logic       ref_clk,
  input wire logic       srst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  // core and pins
  input wire logic       conv_irq,
  input wire logic       converter_on,
  input wire logic       reference_select,
  input wire logic [1:0] channel_select,
  input wire logic       sample_hold,
  input wire logic       hold_discharge,
  input wire logic [3:0] pin_analog_select
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  logic wc;
  assign wc = reg_wr && reg_addr == CONTROL_ADDR;
  sequence go_clear_s;
    wc && !reg_wdata[GO_BIT] ##[1:2] reg_rd && reg_addr == CONTROL_ADDR;
  endsequence
  AST_RESET_PINS: assert property ($fell(srst) |-> pin_analog_select == 4'hF)
    else $error("pins not analog after reset");
  AST_RESET_OFF: assert property ($fell(srst) |-> !converter_on && !reference_select)
    else $error("converter on after reset");
  AST_CTRL_WR: assert property (wc |=> {reference_select, channel_select} ==
    {$past(reg_wdata[REF_BIT]), $past(reg_wdata[3:2])} &&
    converter_on == $past(reg_wdata[ON_BIT]))
    else $error("control fields not taken");
  AST_PIN_WR: assert property (reg_wr && reg_addr == PIN_CLK_ADDR
    |=> pin_analog_select == $past(reg_wdata[3:0])) else $error("pin select not taken");
  AST_UNIMPL: assert property (reg_rd && reg_addr == CONTROL_ADDR |=> reg_rdata[5:4] == 2'h0)
    else $error("unimplemented bits read one");
  AST_NO_DISCHARGE: assert property (!hold_discharge)
    else $error("hold discharged");
  AST_GO_CLEAR: assert property (go_clear_s |=> !reg_rdata[GO_BIT])
    else $error("go still set after clear");
  AST_IRQ_MASK: assert property (reg_wr && reg_addr == ENABLE_ADDR && !reg_wdata[DONE_BIT]
    |=> ##1 !conv_irq) else $error("request while masked");
  AST_OFF_IDLE: assert property (!converter_on ##1 !converter_on |-> !sample_hold)
    else $error("sampling while off");
endmodule : adc_ctrl_chk
bind adc_conversion_control adc_ctrl_chk chk (.ref_clk, .srst, .reg_addr, .reg_wdata,
  .reg_wr, .reg_rd, .reg_rdata, .conv_irq, .converter_on, .reference_select,
  .channel_select, .sample_hold, .hold_discharge, .pin_analog_select);
`default_nettype wire

/* File: testbench.sv */
// register-level tests of the conversion control block
// assumes the analog core model on the far side
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import adc_ctrl_pkg::*;
  localparam logic [39:0] VIN = {10'h2C7, 10'h3FF, 10'h15A, 10'h001};
  logic       ref_clk, srst, reg_wr, reg_rd, conv_irq, comp_high;
  logic       converter_on, reference_select, sample_hold;
  logic [1:0] channel_select;
  logic [3:0] pin_analog_select;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, c;
  logic [9:0] dac_code, r;
  logic [2:0] sel;
  int         n_fail = 0, checks = 0, n, base;
  adc_conversion_control DUT (.ref_clk, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .conv_irq, .comp_high, .dac_code, .converter_on, .reference_select,
    .channel_select, .sample_hold, .hold_discharge(), .pin_analog_select);
  adc_core_model #(.VIN(VIN)) core (.ref_clk, .dac_code, .converter_on, .reference_select,
    .channel_select, .sample_hold, .comp_high);
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : print_verdict
  task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] e);
    checks++;
    if (s !== e) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e, input string nm);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    chk(nm, reg_rdata, e);
  endtask : rdchk
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  initial begin
    srst      = 1'b1;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
    repeat (16) @(posedge ref_clk);
    srst <= 1'b0;
    rdchk(CONTROL_ADDR, 8'h00, "control");
    rdchk(PIN_CLK_ADDR, 8'h0F, "pin_clk");
    rdchk(8'h55, 8'h00, "unmapped");
    wr(PIN_CLK_ADDR, 8'hFF);
    rdchk(PIN_CLK_ADDR, 8'h7F, "pin_clk_unimpl");
    wr(CONTROL_ADDR, 8'hF2);
    rdchk(CONTROL_ADDR, 8'hC0, "go_while_off");
    wr(ENABLE_ADDR, 8'h40);
    for (int s = 0; s < 8; s++) begin
      sel = s[2:0];
      base = (sel[1:0] == 2'h3) ? 11 * RC_DIV + INSTR_CYCLES : 11 * (2 << (2 * sel[1:0] + sel[2]));
      c = {sel[0], sel[2], 2'h0, sel[1:0], 2'h1};
      wr(PIN_CLK_ADDR, {1'b0, sel, 4'hF});
      wr(CONTROL_ADDR, c);
      repeat (8) @(posedge ref_clk);
      wr(CONTROL_ADDR, c | 8'h02);
      n = 0;
      while (conv_irq !== 1'b1 && n < 5000) begin
        @(negedge ref_clk);
        n++;
      end
      if (n == 5000) begin
        n_fail++;
        print_verdict();
      end
      chk("conv_len", {7'h0, n > base && n <= base + 6}, 8'h01);
      r = VIN[sel[1:0] * 10 +: 10] >> sel[2];
      // only bit periods of at least 1.6 us promise a correct code
      if (sel[1] && (sel[0] || sel[2])) begin
        rdchk(RESULT_HI_ADDR, sel[0] ? {6'h00, r[9:8]} : r[9:2], "result_hi");
        rdchk(RESULT_LO_ADDR, sel[0] ? r[7:0] : {r[1:0], 6'h00}, "result_lo");
      end
      rdchk(FLAG_ADDR, 8'h40, "done_flag");
      rdchk(CONTROL_ADDR, c, "go_cleared");
      wr(FLAG_ADDR, 8'h00);
    end
    wr(PIN_CLK_ADDR, 8'h6F);
    wr(CONTROL_ADDR, 8'h81);
    wr(CONTROL_ADDR, 8'h83);
    rdchk(CONTROL_ADDR, 8'h83, "go_busy");
    repeat (100) @(posedge ref_clk);
    wr(CONTROL_ADDR, 8'h81);
    rdchk(CONTROL_ADDR, 8'h81, "go_abort");
    rdchk(RESULT_LO_ADDR, r[7:0], "kept_lo");
    chk("abort_wait", {7'h0, sample_hold}, 8'h00);
    repeat (200) @(negedge ref_clk);
    chk("reacquire", {7'h0, sample_hold}, 8'h01);
    wr(CONTROL_ADDR, 8'h83);
    repeat (50) @(posedge ref_clk);
    srst <= 1'b1;
    @(posedge ref_clk);
    srst <= 1'b0;
    rdchk(CONTROL_ADDR, 8'h00, "reset_off");
    rdchk(RESULT_HI_ADDR, r[9:2], "reset_kept");
    wr(ENABLE_ADDR, 8'h00);
    repeat (4) @(posedge ref_clk);
    print_verdict();
  end
endmodule : testbench
`default_nettype wire
